// file: src/vps_output_stage.sv
// Valve PWM output stage: source selection, ramp, dither, current PID,
// sensor averaging and fault flag. Assumes synchronous inputs, one clock.
`timescale 1ns/1ps
`default_nettype none

module vps_output_stage #(
	parameter int TICK_CYCLES = vps_pkg::VPS_TICK_CYC
) (
	input  wire logic          clk,
	input  wire logic          rst,
	input  wire logic [7:0]    addr,
	input  wire logic [31:0]   wdata,
	input  wire logic          wr,
	input  wire logic          rd,
	output logic [31:0]        rdata,
	input  wire logic [127:0]  src_value,
	input  wire logic [7:0]    src_valid,
	input  wire logic [11:0]   meas_current,
	input  wire logic [12:0]   supply_voltage,
	input  wire logic          short_detect,
	output logic [9:0]         duty,
	output logic [15:0]        sensor_norm,
	output logic               fault_flag
);
	import vps_pkg::*;

	// ****************************************************
	// Helpers
	// ****************************************************
	function automatic logic [15:0] clip16(input logic [31:0] v, input logic [15:0] hi);
		clip16 = (v > {16'h0000, hi}) ? hi : v[15:0];
	endfunction

	// Clamp on the whole bus word so an oversized write cannot wrap into range
	function automatic logic [19:0] clip20(input logic [31:0] v, input logic [19:0] hi);
		clip20 = (v > {12'h000, hi}) ? hi : v[19:0];
	endfunction

	// Restore a physical value from a normalized one
	function automatic logic [15:0] restore(input logic [15:0] n, input logic [15:0] lo,
		input logic [15:0] hi);
		logic [31:0] prod;
		// Scale by n+1 so that full scale lands exactly on the maximum
		prod = 32'(n) * 32'(hi - lo) + 32'(hi - lo);
		restore = lo + prod[31:16];
	endfunction

	// Pick a source word; invalid or unconnected reads zero, never inverted
	function automatic logic [15:0] pick(input logic [3:0] sel, input logic inv,
		input logic [127:0] vals, input logic [7:0] valid);
		logic [2:0] i;
		i = 3'(sel - 4'h1);
		if (sel == VPS_SRC_NONE || sel > 4'(VPS_NSRC) || !valid[i]) begin
			pick = 16'h0000;
		end else begin
			pick = inv ? ~vals[i*16 +: 16] : vals[i*16 +: 16];
		end
	endfunction

	// ****************************************************
	// Registers
	// ****************************************************
	vps_mode_t   mode;
	logic        rev, cinv, dinv, unlocked;
	logic [3:0]  ctl_src, dis_src;
	logic [15:0] imax, imin, vmax, vmin, dmax, dmin, dfreq, damp, avg_ms;
	logic [16:0] rup, rdn;
	logic [19:0] kp, ti, td;

	wire         pid_reg = addr == VPS_REG_KP || addr == VPS_REG_TI || addr == VPS_REG_TD;
	wire         pid_ok  = wr && pid_reg && unlocked;
	wire [19:0]  ramp_w  = clip20(wdata, 20'(VPS_RAMP_MAX));

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mode <= VPS_MODE_CURRENT;
			rev <= 1'b0;
			cinv <= 1'b0;
			dinv <= 1'b0;
			ctl_src <= VPS_SRC_FIRST;
			dis_src <= VPS_SRC_NONE;
			imax <= VPS_IMAX_RST;
			imin <= VPS_IMIN_RST;
			vmax <= VPS_VMAX_RST;
			vmin <= VPS_VMIN_RST;
			dmax <= VPS_DMAX_RST;
			dmin <= VPS_DMIN_RST;
			rup <= VPS_RAMP_RST;
			rdn <= VPS_RAMP_RST;
			dfreq <= VPS_DFREQ_RST;
			damp <= VPS_DAMP_RST;
			kp <= VPS_KP_RST;
			ti <= VPS_TI_RST;
			td <= VPS_TD_RST;
			avg_ms <= VPS_AVG_RST;
			unlocked <= 1'b0;
		end else if (wr) begin
			case (addr)
				VPS_REG_CTRL: begin
					case (wdata[2:0])
						VPS_MODE_OFF, VPS_MODE_DISCRETE, VPS_MODE_CURRENT,
						VPS_MODE_VOLTAGE, VPS_MODE_DUTY: mode <= vps_mode_t'(wdata[2:0]);
						default: mode <= mode;
					endcase
					rev <= wdata[VPS_CTRL_REV];
					cinv <= wdata[VPS_CTRL_CINV];
					dinv <= wdata[VPS_CTRL_DINV];
				end
				VPS_REG_SRC: begin
					ctl_src <= wdata[3:0];
					dis_src <= wdata[VPS_SRC_DIS_LSB +: 4];
				end
				VPS_REG_IMAX: imax <= clip16(wdata, VPS_I_LIMIT);
				VPS_REG_IMIN: imin <= clip16(wdata, VPS_I_LIMIT);
				VPS_REG_VMAX: vmax <= clip16(wdata, VPS_V_LIMIT);
				VPS_REG_VMIN: vmin <= clip16(wdata, VPS_V_LIMIT);
				VPS_REG_DMAX: dmax <= clip16(wdata, VPS_D_LIMIT);
				VPS_REG_DMIN: dmin <= clip16(wdata, VPS_D_LIMIT);
				VPS_REG_RUP: rup <= ramp_w[16:0];
				VPS_REG_RDN: rdn <= ramp_w[16:0];
				VPS_REG_DFREQ: begin
					if (wdata < 32'(VPS_DFREQ_LO)) begin
						dfreq <= VPS_DFREQ_LO;
					end else begin
						dfreq <= clip16(wdata, VPS_DFREQ_HI);
					end
				end
				VPS_REG_DAMP: damp <= clip16(wdata, VPS_DAMP_MAX);
				VPS_REG_AVG: avg_ms <= clip16(wdata, VPS_AVG_MAX);
				VPS_REG_KEY: unlocked <= wdata == VPS_PID_KEY;
				default: begin
				end
			endcase
			// Each key unlocks one coefficient write only
			if (pid_ok) begin
				unlocked <= 1'b0;
				case (addr)
					VPS_REG_KP: kp <= clip20(wdata, VPS_KP_MAX);
					VPS_REG_TI: ti <= clip20(wdata, VPS_T_MAX);
					default: td <= clip20(wdata, VPS_T_MAX);
				endcase
			end
		end
	end

	// ****************************************************
	// Control path
	// ****************************************************
	wire [15:0] ctl_n   = pick(ctl_src, cinv, src_value, src_valid);
	wire [15:0] dis_n   = pick(dis_src, dinv, src_value, src_valid);
	wire        dis_on  = dis_n >= VPS_NORM_HALF;
	wire [15:0] rev_n   = rev ? ~ctl_n : ctl_n;
	wire [15:0] dis_lvl = rev ? VPS_NORM_FULL : 16'h0000;
	wire        forced  = dis_on || mode == VPS_MODE_OFF;
	wire [15:0] disc_n  = (ctl_n >= VPS_NORM_HALF) ^ rev ? VPS_NORM_FULL : 16'h0000;
	wire [15:0] target  = forced ? dis_lvl : (mode == VPS_MODE_DISCRETE) ? disc_n : rev_n;

	// ****************************************************
	// Ramp limiter
	// ****************************************************
	// Pace gains the full span each clock; each ramp time in clocks that it
	// holds is one LSB, so a short ramp moves several LSBs per clock.
	logic [15:0] level;
	logic [31:0] pace;
	wire         going_up  = target > level;
	wire  [16:0] ramp_ms   = going_up ? rup : rdn;
	wire  [31:0] ramp_thr  = 32'(ramp_ms) * 32'(TICK_CYCLES);
	wire  [31:0] pace_next = pace + 32'(VPS_NORM_FULL);
	wire  [31:0] step_q    = (ramp_thr == 32'h0) ? 32'h0 : pace_next / ramp_thr;
	wire  [31:0] step_r    = pace_next - step_q * ramp_thr;
	wire  [15:0] gap       = going_up ? target - level : level - target;
	wire  [15:0] step_n    = step_q[15:0];

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			level <= 16'h0000;
			pace <= 32'h0000_0000;
		end else if (forced || ramp_ms == 17'h00000) begin
			level <= target;
			pace <= 32'h0000_0000;
		end else if (level == target) begin
			pace <= 32'h0000_0000;
		end else if (step_q >= 32'(gap)) begin
			pace <= 32'h0000_0000;
			level <= target;
		end else begin
			pace <= step_r;
			level <= going_up ? level + step_n : level - step_n;
		end
	end

	// ****************************************************
	// Scaling and dither
	// ****************************************************
	logic [15:0] lo, hi;
	always_comb begin
		case (mode)
			VPS_MODE_VOLTAGE: begin
				lo = vmin;
				hi = vmax;
			end
			VPS_MODE_DUTY: begin
				lo = dmin;
				hi = dmax;
			end
			default: begin
				lo = imin;
				hi = imax;
			end
		endcase
	end

	wire [15:0] phys    = restore(level, lo, hi);
	wire [31:0] pp_raw  = 32'(hi) * 32'(damp) / 32'd1000;
	wire [15:0] i_room  = VPS_PEAK_MA - imax;
	wire [15:0] pp      = (mode == VPS_MODE_CURRENT) ? clip16(pp_raw, i_room)
		: pp_raw[15:0];
	wire [15:0] half    = {1'b0, pp[15:1]};

	logic        dth_hi;
	logic [31:0] dth_acc;
	wire  [31:0] dth_next = dth_acc + 32'({dfreq, 1'b0});

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dth_acc <= 32'h0000_0000;
			dth_hi <= 1'b0;
		end else if (dth_next >= 32'(VPS_DTH_DEN)) begin
			dth_acc <= dth_next - 32'(VPS_DTH_DEN);
			dth_hi <= ~dth_hi;
		end else begin
			dth_acc <= dth_next;
		end
	end

	// Dither stays off the disabled state so a forced output is exact
	wire        dth_use = !forced && mode != VPS_MODE_DISCRETE;
	wire [16:0] cmd_up  = 17'(phys) + 17'(half);
	wire [15:0] cmd     = !dth_use ? phys : dth_hi ? cmd_up[15:0]
		: (phys > half) ? phys - half : 16'h0000;

	// ****************************************************
	// Current loop
	// ****************************************************
	logic [31:0] tick_cnt;
	wire         tick = tick_cnt == 32'(TICK_CYCLES - 1);
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tick_cnt <= 32'h0000_0000;
		end else begin
			tick_cnt <= tick ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
		end
	end

	logic signed [31:0] integ;
	logic signed [17:0] err_prev;
	logic        [9:0]  pid_duty;
	wire  signed [17:0] err    = $signed({2'b00, cmd}) - $signed({6'h00, meas_current});
	wire  signed [31:0] i_term = (ti == 20'h00000) ? 32'sh0 : integ / $signed({12'h000, ti});
	wire  signed [31:0] d_term = $signed({12'h000, td}) * 32'(err - err_prev) / 32'sd10;
	wire  signed [63:0] u_raw  = $signed({44'h0, kp}) * 64'(32'(err) + i_term + d_term)
		/ 64'sd1000;
	wire  [9:0]         u_sat  = (u_raw < 64'sh0) ? 10'h000
		: (u_raw > 64'(VPS_DUTY_FULL)) ? VPS_DUTY_FULL : u_raw[9:0];

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			integ <= 32'sh0;
			err_prev <= 18'sh0;
			pid_duty <= 10'h000;
		end else if (mode != VPS_MODE_CURRENT || forced) begin
			integ <= 32'sh0;
			err_prev <= 18'sh0;
			pid_duty <= 10'h000;
		end else if (tick) begin
			integ <= integ + 32'(err) * 32'sd10;
			err_prev <= err;
			pid_duty <= u_sat;
		end
	end

	// ****************************************************
	// Duty selection
	// ****************************************************
	wire [31:0] v_duty  = (supply_voltage == 13'h0000) ? 32'h0
		: 32'(cmd) * 32'(VPS_DUTY_FULL) / 32'(supply_voltage);
	wire [15:0] v_clip  = clip16(v_duty, 16'(VPS_DUTY_FULL));
	wire [15:0] d_clip  = clip16(32'(cmd), 16'(VPS_DUTY_FULL));
	logic [9:0] next_duty;
	always_comb begin
		case (mode)
			VPS_MODE_OFF: next_duty = rev ? VPS_DUTY_FULL : 10'h000;
			VPS_MODE_DISCRETE: next_duty = level[15] ? VPS_DUTY_FULL : 10'h000;
			VPS_MODE_CURRENT: next_duty = forced && rev ? VPS_DUTY_FULL : pid_duty;
			VPS_MODE_VOLTAGE: next_duty = v_clip[9:0];
			VPS_MODE_DUTY: next_duty = d_clip[9:0];
			default: next_duty = 10'h000;
		endcase
	end

	// ****************************************************
	// Sensor averaging and fault
	// ****************************************************
	logic [15:0] avg_cnt;
	logic [27:0] avg_sum;
	logic [11:0] avg_val;
	wire  [27:0] sum_next = avg_sum + 28'(meas_current);
	wire  [31:0] norm_raw = 32'(avg_val) * 32'(VPS_NORM_FULL) / 32'(VPS_SENS_MAX);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			avg_cnt <= 16'h0000;
			avg_sum <= 28'h000_0000;
			avg_val <= 12'h000;
			duty <= 10'h000;
			sensor_norm <= 16'h0000;
			fault_flag <= 1'b0;
		end else begin
			duty <= next_duty;
			sensor_norm <= clip16(norm_raw, VPS_NORM_FULL);
			fault_flag <= short_detect;
			if (tick) begin
				if (avg_ms == 16'h0000) begin
					avg_val <= meas_current;
				end else if (avg_cnt + 16'h0001 >= avg_ms) begin
					avg_val <= 12'(sum_next / 28'(avg_ms));
					avg_cnt <= 16'h0000;
					avg_sum <= 28'h000_0000;
				end else begin
					avg_cnt <= avg_cnt + 16'h0001;
					avg_sum <= sum_next;
				end
			end
		end
	end

	// ****************************************************
	// Read port
	// ****************************************************
	logic [31:0] next_rdata;
	always_comb begin
		case (addr)
			VPS_REG_CTRL: next_rdata = {25'h0, dinv, cinv, rev, 1'b0, mode};
			VPS_REG_SRC: next_rdata = {20'h0, dis_src, 4'h0, ctl_src};
			VPS_REG_IMAX: next_rdata = {16'h0, imax};
			VPS_REG_IMIN: next_rdata = {16'h0, imin};
			VPS_REG_VMAX: next_rdata = {16'h0, vmax};
			VPS_REG_VMIN: next_rdata = {16'h0, vmin};
			VPS_REG_DMAX: next_rdata = {16'h0, dmax};
			VPS_REG_DMIN: next_rdata = {16'h0, dmin};
			VPS_REG_RUP: next_rdata = {15'h0, rup};
			VPS_REG_RDN: next_rdata = {15'h0, rdn};
			VPS_REG_DFREQ: next_rdata = {16'h0, dfreq};
			VPS_REG_DAMP: next_rdata = {16'h0, damp};
			VPS_REG_KP: next_rdata = {12'h0, kp};
			VPS_REG_TI: next_rdata = {12'h0, ti};
			VPS_REG_TD: next_rdata = {12'h0, td};
			VPS_REG_KEY: next_rdata = {31'h0, unlocked};
			VPS_REG_AVG: next_rdata = {16'h0, avg_ms};
			VPS_REG_STATUS: next_rdata = {3'h0, fault_flag, avg_val, sensor_norm};
			VPS_REG_LEVEL: next_rdata = {6'h0, duty, level};
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata <= 32'h0000_0000;
		end else begin
			rdata <= rd ? next_rdata : 32'h0000_0000;
		end
	end

endmodule

`default_nettype wire

// file: src/vps_pkg.sv
// Constants, field layouts and modes of the valve PWM output stage.
// Assumes a 10 MHz clock and a plain strobe-and-address register port.

package vps_pkg;

	typedef enum logic [2:0] {
		VPS_MODE_OFF      = 3'h0,
		VPS_MODE_DISCRETE = 3'h1,
		VPS_MODE_CURRENT  = 3'h3,
		VPS_MODE_VOLTAGE  = 3'h2,
		VPS_MODE_DUTY     = 3'h6
	} vps_mode_t;

	// Register word offsets
	localparam logic [7:0] VPS_REG_CTRL    = 8'h00;
	localparam logic [7:0] VPS_REG_SRC     = 8'h04;
	localparam logic [7:0] VPS_REG_IMAX    = 8'h08;
	localparam logic [7:0] VPS_REG_IMIN    = 8'h0C;
	localparam logic [7:0] VPS_REG_VMAX    = 8'h10;
	localparam logic [7:0] VPS_REG_VMIN    = 8'h14;
	localparam logic [7:0] VPS_REG_DMAX    = 8'h18;
	localparam logic [7:0] VPS_REG_DMIN    = 8'h1C;
	localparam logic [7:0] VPS_REG_RUP     = 8'h20;
	localparam logic [7:0] VPS_REG_RDN     = 8'h24;
	localparam logic [7:0] VPS_REG_DFREQ   = 8'h28;
	localparam logic [7:0] VPS_REG_DAMP    = 8'h2C;
	localparam logic [7:0] VPS_REG_KP      = 8'h30;
	localparam logic [7:0] VPS_REG_TI      = 8'h34;
	localparam logic [7:0] VPS_REG_TD      = 8'h38;
	localparam logic [7:0] VPS_REG_KEY     = 8'h3C;
	localparam logic [7:0] VPS_REG_AVG     = 8'h40;
	localparam logic [7:0] VPS_REG_STATUS  = 8'h44;
	localparam logic [7:0] VPS_REG_LEVEL   = 8'h48;

	// Control and source register fields
	localparam int VPS_CTRL_MODE_LSB = 0;
	localparam int VPS_CTRL_REV      = 4;
	localparam int VPS_CTRL_CINV     = 5;
	localparam int VPS_CTRL_DINV     = 6;
	localparam int VPS_SRC_DIS_LSB   = 8;

	// Sources: 0 is unconnected, 1..8 are the logical outputs wired in
	localparam int         VPS_NSRC       = 8;
	localparam logic [3:0] VPS_SRC_NONE   = 4'h0;
	localparam logic [3:0] VPS_SRC_FIRST  = 4'h1;

	// Units: mA, 10 mV, 0.1 %, ms, 0.1 Hz, PID gain 0.001, times 0.1 ms
	localparam logic [15:0] VPS_IMAX_RST  = 16'h03E8;
	localparam logic [15:0] VPS_IMIN_RST  = 16'h0000;
	localparam logic [15:0] VPS_I_LIMIT   = 16'h0BB8;
	localparam logic [15:0] VPS_VMAX_RST  = 16'h0960;
	localparam logic [15:0] VPS_VMIN_RST  = 16'h0000;
	localparam logic [15:0] VPS_V_LIMIT   = 16'h1770;
	localparam logic [15:0] VPS_DMAX_RST  = 16'h03E8;
	localparam logic [15:0] VPS_DMIN_RST  = 16'h0000;
	localparam logic [15:0] VPS_D_LIMIT   = 16'h03E8;
	localparam logic [16:0] VPS_RAMP_RST  = 17'h0000A;
	localparam logic [16:0] VPS_RAMP_MAX  = 17'h186A0;
	localparam logic [15:0] VPS_DFREQ_RST = 16'h03E8;
	localparam logic [15:0] VPS_DFREQ_LO  = 16'h00C8;
	localparam logic [15:0] VPS_DFREQ_HI  = 16'h0FA0;
	localparam logic [15:0] VPS_DAMP_RST  = 16'h0032;
	localparam logic [15:0] VPS_DAMP_MAX  = 16'h0190;
	localparam logic [15:0] VPS_PEAK_MA   = 16'h0C4E;
	localparam logic [19:0] VPS_KP_RST    = 20'h00320;
	localparam logic [19:0] VPS_KP_MAX    = 20'hF4240;
	localparam logic [19:0] VPS_TI_RST    = 20'h0012C;
	localparam logic [19:0] VPS_TD_RST    = 20'h0000A;
	localparam logic [19:0] VPS_T_MAX     = 20'h186A0;
	localparam logic [15:0] VPS_AVG_RST   = 16'h0064;
	localparam logic [15:0] VPS_AVG_MAX   = 16'h03E8;
	localparam logic [15:0] VPS_SENS_MAX  = 16'h0BB8;
	localparam logic [9:0]  VPS_DUTY_FULL = 10'h3E8;
	localparam logic [15:0] VPS_NORM_HALF = 16'h8000;
	localparam logic [15:0] VPS_NORM_FULL = 16'hFFFF;

	// Unlock key for the PID coefficients; value is arbitrary
	localparam logic [31:0] VPS_PID_KEY   = 32'h5049_4453;

	// Timing
	localparam int CLK_HZ        = 10_000_000;
	localparam int VPS_TICK_MS   = 1;
	localparam int VPS_TICK_CYC  = CLK_HZ / 1000 * VPS_TICK_MS;
	localparam int VPS_DTH_DEN   = CLK_HZ * 10;

endpackage

// file: testbench/vps_output_stage_assertions.sv
// Port checker for the valve PWM output stage.
// Assumes the top ports only; bound into every instance of the stage.
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Checker
// ****************************************
module vps_output_stage_assertions #(
	parameter int TICK_CYCLES = vps_pkg::VPS_TICK_CYC
) (
	input wire logic         clk,
	input wire logic         rst,
	input wire logic [7:0]   addr,
	input wire logic [31:0]  wdata,
	input wire logic         wr,
	input wire logic         rd,
	input wire logic [31:0]  rdata,
	input wire logic [127:0] src_value,
	input wire logic [7:0]   src_valid,
	input wire logic [11:0]  meas_current,
	input wire logic [12:0]  supply_voltage,
	input wire logic         short_detect,
	input wire logic [9:0]   duty,
	input wire logic [15:0]  sensor_norm,
	input wire logic         fault_flag
);
	import vps_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	chk_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0)
		else $error("read data outside its cycle");
	chk_fault_follow: assert property (1'b1 |=> fault_flag == $past(short_detect))
		else $error("fault flag does not follow short");
	chk_duty_range: assert property (duty <= VPS_DUTY_FULL)
		else $error("duty above full scale");
	chk_key_unlock: assert property ((wr && addr == VPS_REG_KEY && wdata == VPS_PID_KEY)
		##2 (rd && addr == VPS_REG_KEY) |=> rdata[0]) else $error("key did not unlock");
	chk_kp_relock: assert property ((wr && addr == VPS_REG_KP) ##2
		(rd && addr == VPS_REG_KEY) |=> !rdata[0]) else $error("lock not restored");
	chk_imax_clamp: assert property ((wr && addr == VPS_REG_IMAX && wdata > 32'd3000)
		##2 (rd && addr == VPS_REG_IMAX) |=> rdata == 32'd3000) else $error("imax not clamped");
	chk_imax_store: assert property ((wr && addr == VPS_REG_IMAX && wdata <= 32'd3000)
		##2 (rd && addr == VPS_REG_IMAX) |=> rdata == ($past(wdata, 3) & 32'h0000FFFF))
		else $error("imax not stored");
	chk_avg_clamp: assert property ((wr && addr == VPS_REG_AVG && wdata > 32'd1000)
		##2 (rd && addr == VPS_REG_AVG) |=> rdata == 32'd1000) else $error("avg not clamped");
	chk_status_sensor: assert property ((rd && addr == VPS_REG_STATUS) ##1 $stable(sensor_norm)
		|-> rdata[15:0] == sensor_norm) else $error("status sensor mismatch");

	cov_key: cover property (wr && addr == VPS_REG_KEY && wdata == VPS_PID_KEY);
	cov_status: cover property (rd && addr == VPS_REG_STATUS);
	cov_short: cover property (short_detect ##1 fault_flag);
endmodule

bind vps_output_stage vps_output_stage_assertions #(.TICK_CYCLES(TICK_CYCLES))
	vps_output_stage_assertions_inst (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
	.wr(wr), .rd(rd), .rdata(rdata), .src_value(src_value), .src_valid(src_valid),
	.meas_current(meas_current), .supply_voltage(supply_voltage),
	.short_detect(short_detect), .duty(duty), .sensor_norm(sensor_norm),
	.fault_flag(fault_flag));
`default_nettype wire

// file: testbench/vps_valve_model.sv
// Solenoid load with current sensor facing the output stage.
// Assumes the stage clock; short is commanded by the bench.
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Load model
// ****************************************
module vps_valve_model (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic [9:0]  duty,
	input wire logic        short_cmd,
	output logic [11:0]     meas_current,
	output logic            short_detect
);
	// Full duty draws 3 A, so the sensor span is used end to end
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			meas_current <= 12'h000;
		else
			meas_current <= 12'(duty * 3);
	end
	assign short_detect = short_cmd;
endmodule
`default_nettype wire

// file: testbench/vps_output_stage_tb.sv
// Self-checking bench for the valve PWM output stage.
// Assumes the load model beside it and a shortened tick of 10 clocks.
`timescale 1ns/1ps
`default_nettype none

// ****************************************
// Bench
// ****************************************
module vps_output_stage_tb;
	import vps_pkg::*;
	logic         clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, short_cmd = 1'b0;
	logic [7:0]   addr = 8'h00, src_valid = 8'hFF;
	logic [31:0]  wdata = 32'h0, rdata, v;
	logic [127:0] src_value = '0;
	logic [11:0]  meas_current;
	logic         short_detect, fault_flag;
	logic [9:0]   duty, lo, hi, prev;
	logic [15:0]  sensor_norm;
	int           n_mismatch = 0, compares = 0, cycles = 0, flips;
	logic [39:0]  rtbl [17] = '{{VPS_REG_CTRL, 32'h3}, {VPS_REG_SRC, 32'h1},
		{VPS_REG_IMAX, 16'h0, VPS_IMAX_RST}, {VPS_REG_IMIN, 16'h0, VPS_IMIN_RST},
		{VPS_REG_VMAX, 16'h0, VPS_VMAX_RST}, {VPS_REG_VMIN, 16'h0, VPS_VMIN_RST},
		{VPS_REG_DMAX, 16'h0, VPS_DMAX_RST}, {VPS_REG_DMIN, 16'h0, VPS_DMIN_RST},
		{VPS_REG_RUP, 15'h0, VPS_RAMP_RST}, {VPS_REG_RDN, 15'h0, VPS_RAMP_RST},
		{VPS_REG_DFREQ, 16'h0, VPS_DFREQ_RST}, {VPS_REG_DAMP, 16'h0, VPS_DAMP_RST},
		{VPS_REG_KP, 12'h0, VPS_KP_RST}, {VPS_REG_TI, 12'h0, VPS_TI_RST},
		{VPS_REG_TD, 12'h0, VPS_TD_RST}, {VPS_REG_KEY, 32'h0},
		{VPS_REG_AVG, 16'h0, VPS_AVG_RST}};
	logic [71:0]  ctbl [9] = '{{VPS_REG_IMAX, 64'h1388_00000BB8},
		{VPS_REG_VMAX, 64'h2328_00001770}, {VPS_REG_DMAX, 64'h7D0_000003E8},
		{VPS_REG_RUP, 64'h30D40_000186A0},
		{VPS_REG_RDN, 64'h30D40_000186A0}, {VPS_REG_DFREQ, 64'h0A_000000C8},
		{VPS_REG_DFREQ, 64'h270F_00000FA0}, {VPS_REG_DAMP, 64'h3E7_00000190},
		{VPS_REG_AVG, 64'h1388_000003E8}};
	logic [79:0]  otbl [13] = '{80'h06_0001_FFFF_0000_FF_03E8, 80'h06_0001_0000_0000_FF_0000,
		80'h26_0001_0000_0000_FF_03E8, 80'h26_0001_FFFF_0000_FE_0000,
		80'h16_0001_FFFF_0000_FF_0000, 80'h06_0201_FFFF_FFFF_FF_0000,
		80'h16_0201_FFFF_FFFF_FF_03E8, 80'h46_0201_FFFF_0000_FF_0000,
		80'h00_0001_FFFF_0000_FF_0000, 80'h01_0001_8000_0000_FF_03E8,
		80'h01_0001_7FFF_0000_FF_0000, 80'h02_0001_FFFF_0000_FF_01F4,
		80'h06_0000_FFFF_0000_FF_0000};
	vps_mode_t    modes [5] = '{VPS_MODE_OFF, VPS_MODE_DISCRETE, VPS_MODE_CURRENT,
		VPS_MODE_VOLTAGE, VPS_MODE_DUTY};

	vps_output_stage #(.TICK_CYCLES(10)) vps_output_stage_inst (.clk(clk), .rst(rst),
		.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .src_value(src_value),
		.src_valid(src_valid), .meas_current(meas_current), .supply_voltage(13'd2400),
		.short_detect(short_detect), .duty(duty), .sensor_norm(sensor_norm),
		.fault_flag(fault_flag));
	vps_valve_model vps_valve_model_inst (.clk(clk), .rst(rst), .duty(duty),
		.short_cmd(short_cmd), .meas_current(meas_current), .short_detect(short_detect));

	initial begin
		forever #50 clk = ~clk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// Tolerance absorbs rounding of the normalized scale
	task automatic near(input logic [31:0] seen, input logic [31:0] exp, input logic [31:0] tol);
		chk((seen + tol >= exp && seen <= exp + tol) ? exp : seen, exp);
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic complete_run;
		$display("compares=%0d mismatches=%0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	always @(posedge clk) begin
		cycles++;
		if (cycles == 60000) begin
			n_mismatch++;
			complete_run();
		end
	end

	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		foreach (rtbl[i]) begin
			rd_reg(rtbl[i][39:32], v);
			chk(v, rtbl[i][31:0]);
		end
		$display("test reset values done");
		foreach (ctbl[i]) begin
			wr_reg(ctbl[i][71:64], ctbl[i][63:32]);
			rd_reg(ctbl[i][71:64], v);
			chk(v, ctbl[i][31:0]);
		end
		foreach (modes[i]) begin
			wr_reg(VPS_REG_CTRL, 32'(modes[i]));
			rd_reg(VPS_REG_CTRL, v);
			chk(v, 32'(modes[i]));
		end
		wr_reg(VPS_REG_CTRL, 32'h7);
		rd_reg(VPS_REG_CTRL, v);
		chk(v, 32'(VPS_MODE_DUTY));
		$display("test limits and modes done");
		wr_reg(VPS_REG_KP, 32'd500);
		rd_reg(VPS_REG_KP, v);
		chk(v, 32'(VPS_KP_RST));
		wr_reg(VPS_REG_KEY, VPS_PID_KEY);
		rd_reg(VPS_REG_KEY, v);
		chk(v, 32'h1);
		wr_reg(VPS_REG_KP, 32'd500);
		rd_reg(VPS_REG_KEY, v);
		chk(v, 32'h0);
		wr_reg(VPS_REG_KP, 32'd600);
		rd_reg(VPS_REG_KP, v);
		chk(v, 32'd500);
		$display("test pid lock done");
		wr_reg(VPS_REG_RUP, 32'h0);
		wr_reg(VPS_REG_RDN, 32'h0);
		wr_reg(VPS_REG_DAMP, 32'h0);
		wr_reg(VPS_REG_VMAX, 32'd1200);
		foreach (otbl[i]) begin
			wr_reg(VPS_REG_CTRL, 32'(otbl[i][79:72]));
			wr_reg(VPS_REG_SRC, 32'(otbl[i][71:56]));
			src_value[31:0] <= {otbl[i][39:24], otbl[i][55:40]};
			src_valid <= otbl[i][23:16];
			repeat (20) @(posedge clk);
			#1 near(duty, 32'(otbl[i][15:0]), 2);
		end
		$display("test output control done");
		wr_reg(VPS_REG_RUP, 32'd5);
		wr_reg(VPS_REG_SRC, 32'h1);
		repeat (25) @(posedge clk);
		#1 near(duty, 32'd500, 60);
		repeat (40) @(posedge clk);
		#1 chk(duty, 32'd1000);
		wr_reg(VPS_REG_RDN, 32'd5);
		src_value[15:0] <= 16'h0;
		repeat (25) @(posedge clk);
		#1 near(duty, 32'd500, 60);
		repeat (40) @(posedge clk);
		#1 chk(duty, 32'd0);
		$display("test ramps done");
		wr_reg(VPS_REG_DAMP, 32'd100);
		wr_reg(VPS_REG_DFREQ, 32'd4000);
		src_value[15:0] <= 16'h8000;
		repeat (40) @(posedge clk);
		lo = 10'h3FF;
		hi = 10'h0;
		flips = 0;
		#1 prev = duty;
		repeat (25000) begin
			@(posedge clk);
			#1 flips += (duty != prev);
			prev = duty;
			lo = (duty < lo) ? duty : lo;
			hi = (duty > hi) ? duty : hi;
		end
		chk(flips, 2);
		near(lo, 32'd450, 3);
		near(hi, 32'd550, 3);
		$display("test dither done");
		wr_reg(VPS_REG_DAMP, 32'h0);
		wr_reg(VPS_REG_AVG, 32'd1);
		repeat (60) @(posedge clk);
		rd_reg(VPS_REG_STATUS, v);
		near(v[15:0], 32'h7FFF, 32'h40);
		near(v[27:16], 32'd1500, 4);
		near(sensor_norm, 32'h7FFF, 32'h40);
		short_cmd <= 1'b1;
		repeat (3) @(posedge clk);
		#1 chk(fault_flag, 1'b1);
		rd_reg(VPS_REG_STATUS, v);
		chk(v[28], 1'b1);
		short_cmd <= 1'b0;
		$display("test sensor and fault done");
		// Load draws 3 mA per per mille, so a gain near one would ring
		wr_reg(VPS_REG_KEY, VPS_PID_KEY);
		wr_reg(VPS_REG_KP, 32'd100);
		wr_reg(VPS_REG_KEY, VPS_PID_KEY);
		wr_reg(VPS_REG_TI, 32'd30);
		wr_reg(VPS_REG_KEY, VPS_PID_KEY);
		wr_reg(VPS_REG_TD, 32'd0);
		rd_reg(VPS_REG_TD, v);
		chk(v, 32'd0);
		wr_reg(VPS_REG_IMAX, 32'd1000);
		rd_reg(VPS_REG_IMAX, v);
		chk(v, 32'd1000);
		wr_reg(VPS_REG_CTRL, 32'(VPS_MODE_CURRENT));
		src_value[15:0] <= 16'hFFFF;
		repeat (4000) @(posedge clk);
		rd_reg(VPS_REG_STATUS, v);
		near(v[27:16], 32'd1000, 150);
		$display("test current loop done");
		complete_run();
	end
endmodule
`default_nettype wire
